// >>> msq_pkg.sv
package msq_pkg;

  // Array dimensions of the sequencer.
  localparam int unsigned NUM_INPUTS   = 14;
  localparam int unsigned NUM_STATE    = 8;
  localparam int unsigned NUM_OUT      = 4;
  localparam int unsigned NUM_SHARED   = 2;
  localparam int unsigned NUM_TERMS    = 48;
  localparam int unsigned NUM_VARS     = NUM_INPUTS + NUM_STATE;
  localparam int unsigned VAR_CMPL     = NUM_VARS;
  localparam int unsigned NUM_REG_BITS = NUM_STATE + NUM_OUT;
  localparam int unsigned REG_OUT_LSB  = NUM_STATE;
  localparam int unsigned VAR_STATE_LSB = NUM_INPUTS;

  // Diagnostic view: output pins show state bits 2..5, shared pins 6..7.
  localparam int unsigned DIAG_PIN_LSB    = 2;
  localparam int unsigned DIAG_SHARED_LSB = 6;

  // Power-on and preset values.
  localparam logic [NUM_STATE-1:0] STATE_RST = 8'hFF;
  localparam logic [NUM_OUT-1:0]   OUT_RST   = 4'hF;

  // APB register map.
  localparam int unsigned           APB_ADDR_W  = 12;
  localparam logic [APB_ADDR_W-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [APB_ADDR_W-1:0] ADDR_INPUTS = 12'h008;

  localparam int unsigned CTRL_W          = 2;
  localparam int unsigned CTRL_DIAG_BIT   = 0;
  localparam int unsigned CTRL_PRESET_BIT = 1;

  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_OUT_LSB   = 8;
  localparam int unsigned ST_DIAG_BIT  = 12;
  localparam int unsigned ST_RUN_BIT   = 13;
  localparam int unsigned ST_OE_BIT    = 14;

  localparam int unsigned IN_LOGIC_LSB  = 0;
  localparam int unsigned IN_PRESET_BIT = 14;
  localparam int unsigned IN_CLK_BIT    = 15;

  // One link pair per variable plus the complement variable on top.
  typedef logic [NUM_TERMS-1:0][NUM_VARS:0]      msq_and_plane_type;
  typedef logic [NUM_REG_BITS-1:0][NUM_TERMS-1:0] msq_or_plane_type;

  typedef enum logic [2:0] {
    SEQ_HELD      = 3'h1,
    SEQ_WAIT_FALL = 3'h2,
    SEQ_RUN       = 3'h4
  } msq_seq_type;

endpackage

// >>> msq_array_if.sv
`timescale 1ns/1ps
interface msq_array_if;
  logic [msq_pkg::NUM_VARS-1:0]     vars;
  logic [msq_pkg::NUM_TERMS-1:0]    terms;
  logic                             cmpl;
  logic [msq_pkg::NUM_REG_BITS-1:0] q;
  logic [msq_pkg::NUM_REG_BITS-1:0] q_nxt;

  modport and_side (input vars, output terms, output cmpl);
  modport or_side  (input terms, input q, output q_nxt);
  modport core     (output vars, output q, input q_nxt, input cmpl, input terms);
endinterface

// >>> msq_and_array.sv
`timescale 1ns/1ps
module msq_and_array #(
  parameter msq_pkg::msq_and_plane_type        AND_TRUE = '1,
  parameter msq_pkg::msq_and_plane_type        AND_COMP = '1,
  parameter logic [msq_pkg::NUM_TERMS-1:0]     CMPL_SEL = '0
) (
  msq_array_if.and_side arr
);

  logic [msq_pkg::NUM_TERMS-1:0] raw;

  // The complement variable is built from the terms without their own complement link,
  // so no combinational loop can form through it.
  genvar t;
  generate
    for (t = 0; t < msq_pkg::NUM_TERMS; t++) begin : g_term
      assign raw[t] = &((~AND_TRUE[t][msq_pkg::NUM_VARS-1:0] | arr.vars) &
                        (~AND_COMP[t][msq_pkg::NUM_VARS-1:0] | ~arr.vars));
      assign arr.terms[t] = raw[t] & (~AND_TRUE[t][msq_pkg::VAR_CMPL] | arr.cmpl) &
                            (~AND_COMP[t][msq_pkg::VAR_CMPL] | ~arr.cmpl);
    end
  endgenerate

  assign arr.cmpl = ~|(raw & CMPL_SEL);

endmodule

// >>> msq_or_array.sv
`timescale 1ns/1ps
module msq_or_array #(
  parameter msq_pkg::msq_or_plane_type SET_PLANE = '0,
  parameter msq_pkg::msq_or_plane_type RST_PLANE = '0
) (
  msq_array_if.or_side arr
);

  logic [msq_pkg::NUM_REG_BITS-1:0] set_cmd;
  logic [msq_pkg::NUM_REG_BITS-1:0] rst_cmd;

  genvar b;
  generate
    for (b = 0; b < msq_pkg::NUM_REG_BITS; b++) begin : g_bit
      assign set_cmd[b] = |(arr.terms & SET_PLANE[b]);
      assign rst_cmd[b] = |(arr.terms & RST_PLANE[b]);
      // Set and reset together is illegal; the bit then simply holds.
      assign arr.q_nxt[b] = (set_cmd[b] & ~rst_cmd[b]) ? 1'b1 :
                            (rst_cmd[b] & ~set_cmd[b]) ? 1'b0 : arr.q[b];
    end
  endgenerate

endmodule

// >>> msq_sequencer.sv
`timescale 1ns/1ps
module msq_sequencer #(
  parameter bit                                PRESET_MODE = 1'b1,
  parameter msq_pkg::msq_and_plane_type        AND_TRUE    = '1,
  parameter msq_pkg::msq_and_plane_type        AND_COMP    = '1,
  parameter logic [msq_pkg::NUM_TERMS-1:0]     CMPL_SEL    = '0,
  parameter msq_pkg::msq_or_plane_type         SET_PLANE   = '0,
  parameter msq_pkg::msq_or_plane_type         RST_PLANE   = '0
) (
  input  wire logic                                       i_sys_clk,
  input  wire logic                                       i_sys_rst,
  input  wire logic                                       i_clk_en,
  input  wire logic                                       i_seq_clk,
  input  wire logic                                       i_logic_or_diag_input,
  input  wire logic [msq_pkg::NUM_INPUTS-1:1]             i_logic_inputs,
  input  wire logic                                       i_diag_select,
  input  wire logic                                       i_preset_or_enable_pin,
  input  wire logic                                       i_psel,
  input  wire logic                                       i_penable,
  input  wire logic                                       i_pwrite,
  input  wire logic [msq_pkg::APB_ADDR_W-1:0]             i_paddr,
  input  wire logic [31:0]                                i_pwdata,
  output logic [31:0]                                     o_prdata,
  output logic                                            o_pready,
  output logic                                            o_pslverr,
  output logic [msq_pkg::NUM_OUT-1:0]                     o_output_pins,
  output logic                                            o_output_pins_oe,
  output logic [msq_pkg::NUM_SHARED-1:0]                  o_shared_state_output_bits,
  output logic                                            o_shared_oe
);

  typedef struct packed {
    logic [msq_pkg::NUM_INPUTS-1:0] in_s1;
    logic [msq_pkg::NUM_INPUTS-1:0] in_s2;
    logic                           ck_s1;
    logic                           ck_s2;
    logic                           ck_prev;
    logic                           pr_s1;
    logic                           pr_s2;
    logic                           dg_s1;
    logic                           dg_s2;
    msq_pkg::msq_seq_type           seq;
    logic [msq_pkg::NUM_STATE-1:0]  state;
    logic [msq_pkg::NUM_OUT-1:0]    outr;
    logic [msq_pkg::NUM_OUT-1:0]    pins;
    logic [msq_pkg::NUM_SHARED-1:0] shared;
    logic                           oe;
    logic [msq_pkg::CTRL_W-1:0]     ctrl;
    logic [31:0]                    prdata;
    logic                           pslverr;
  } msq_core_type;

  msq_core_type core_r;
  msq_core_type core_nxt;

  msq_array_if arr ();

  logic                                 ck_rise;
  logic                                 ck_fall;
  logic                                 preset_act;
  logic                                 diag_act;
  logic                                 apb_setup;
  logic                                 apb_write;
  logic [msq_pkg::NUM_REG_BITS-1:0]     reg_now;

  // Feed the arrays from the synchronised inputs and the stored state bits.
  assign arr.vars = {core_r.state, core_r.in_s2};
  assign reg_now  = {core_r.outr, core_r.state};
  assign arr.q    = reg_now;

  msq_and_array #(
    .AND_TRUE (AND_TRUE),
    .AND_COMP (AND_COMP),
    .CMPL_SEL (CMPL_SEL)
  ) u_and_array (
    .arr (arr.and_side)
  );

  msq_or_array #(
    .SET_PLANE (SET_PLANE),
    .RST_PLANE (RST_PLANE)
  ) u_or_array (
    .arr (arr.or_side)
  );

  // Edge detection looks only at the second synchroniser stage and its delayed copy.
  assign ck_rise = core_r.ck_s2 & ~core_r.ck_prev;
  assign ck_fall = ~core_r.ck_s2 & core_r.ck_prev;

  // In enable mode the pin has no preset meaning; software can still force a preset.
  assign preset_act = (PRESET_MODE & core_r.pr_s2) | core_r.ctrl[msq_pkg::CTRL_PRESET_BIT];

  assign diag_act = core_r.dg_s2 | core_r.ctrl[msq_pkg::CTRL_DIAG_BIT];

  assign apb_setup = i_psel & ~i_penable;
  assign apb_write = i_psel & i_penable & i_pwrite;

  always_comb begin
    core_nxt = core_r;

    // Two-stage synchronisers for every pin that comes from the board.
    core_nxt.in_s1   = {i_logic_inputs, i_logic_or_diag_input};
    core_nxt.in_s2   = core_r.in_s1;
    core_nxt.ck_s1   = i_seq_clk;
    core_nxt.ck_s2   = core_r.ck_s1;
    core_nxt.ck_prev = core_r.ck_s2;
    core_nxt.pr_s1   = i_preset_or_enable_pin;
    core_nxt.pr_s2   = core_r.pr_s1;
    core_nxt.dg_s1   = i_diag_select;
    core_nxt.dg_s2   = core_r.dg_s1;

    // Clocking of the state and output registers.
    if (preset_act) begin
      core_nxt.seq   = msq_pkg::SEQ_HELD;
      core_nxt.state = msq_pkg::STATE_RST;
      core_nxt.outr  = msq_pkg::OUT_RST;
    end else begin
      case (core_r.seq)
        msq_pkg::SEQ_HELD: begin
          core_nxt.seq = msq_pkg::SEQ_WAIT_FALL;
        end
        msq_pkg::SEQ_WAIT_FALL: begin
          // A rising edge seen here is not a full pulse and is ignored.
          if (ck_fall) begin
            core_nxt.seq = msq_pkg::SEQ_RUN;
          end
        end
        msq_pkg::SEQ_RUN: begin
          if (ck_rise) begin
            core_nxt.state = arr.q_nxt[msq_pkg::NUM_STATE-1:0];
            core_nxt.outr  = arr.q_nxt[msq_pkg::REG_OUT_LSB +: msq_pkg::NUM_OUT];
          end
        end
        default: begin
          core_nxt.seq = msq_pkg::SEQ_HELD;
        end
      endcase
    end

    // Output multiplexing only changes what the pins show, never the stored bits.
    if (diag_act) begin
      core_nxt.pins   = core_r.state[msq_pkg::DIAG_PIN_LSB +: msq_pkg::NUM_OUT];
      core_nxt.shared = core_r.state[msq_pkg::DIAG_SHARED_LSB +: msq_pkg::NUM_SHARED];
    end else begin
      core_nxt.pins   = core_r.outr;
      core_nxt.shared = core_r.state[msq_pkg::NUM_SHARED-1:0];
    end
    core_nxt.oe = PRESET_MODE ? 1'b1 : ~core_r.pr_s2;

    // APB: read data and error are prepared in the setup cycle and stand in the access cycle.
    if (apb_setup) begin
      core_nxt.prdata  = '0;
      core_nxt.pslverr = 1'b0;
      case (i_paddr)
        msq_pkg::ADDR_CTRL: begin
          core_nxt.prdata[msq_pkg::CTRL_W-1:0] = core_r.ctrl;
        end
        msq_pkg::ADDR_STATUS: begin
          core_nxt.prdata[msq_pkg::ST_STATE_LSB +: msq_pkg::NUM_STATE] = core_r.state;
          core_nxt.prdata[msq_pkg::ST_OUT_LSB +: msq_pkg::NUM_OUT]     = core_r.outr;
          core_nxt.prdata[msq_pkg::ST_DIAG_BIT] = diag_act;
          core_nxt.prdata[msq_pkg::ST_RUN_BIT]  = (core_r.seq == msq_pkg::SEQ_RUN);
          core_nxt.prdata[msq_pkg::ST_OE_BIT]   = core_r.oe;
        end
        msq_pkg::ADDR_INPUTS: begin
          core_nxt.prdata[msq_pkg::IN_LOGIC_LSB +: msq_pkg::NUM_INPUTS] = core_r.in_s2;
          core_nxt.prdata[msq_pkg::IN_PRESET_BIT] = core_r.pr_s2;
          core_nxt.prdata[msq_pkg::IN_CLK_BIT]    = core_r.ck_s2;
        end
        default: begin
          core_nxt.pslverr = 1'b1;
        end
      endcase
    end

    if (apb_write && (i_paddr == msq_pkg::ADDR_CTRL)) begin
      core_nxt.ctrl = i_pwdata[msq_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      core_r        <= '0;
      core_r.seq    <= msq_pkg::SEQ_HELD;
      core_r.state  <= msq_pkg::STATE_RST;
      core_r.outr   <= msq_pkg::OUT_RST;
      core_r.pins   <= msq_pkg::OUT_RST;
      core_r.shared <= msq_pkg::STATE_RST[msq_pkg::NUM_SHARED-1:0];
      core_r.oe     <= PRESET_MODE;
    end else if (i_clk_en) begin
      core_r <= core_nxt;
    end
  end

  // Zero wait states; a frozen clock enable stretches the access phase, but a setup cycle under it prepares no read data.
  assign o_pready                   = i_clk_en;
  assign o_prdata                   = core_r.prdata;
  assign o_pslverr                  = core_r.pslverr;
  assign o_output_pins              = core_r.pins;
  assign o_output_pins_oe           = core_r.oe;
  assign o_shared_state_output_bits = core_r.shared;
  assign o_shared_oe                = core_r.oe;

endmodule

// >>> msq_monitor.sv
`timescale 1ns/1ps
module msq_monitor #(
  parameter bit PRESET_MODE = 1'b1
) (
  input wire logic                            i_sys_clk,
  input wire logic                            i_sys_rst,
  input wire logic                            i_clk_en,
  input wire logic                            i_seq_clk,
  input wire logic                            i_diag_select,
  input wire logic                            i_preset_or_enable_pin,
  input wire logic                            i_psel,
  input wire logic                            i_penable,
  input wire logic [msq_pkg::APB_ADDR_W-1:0]  i_paddr,
  input wire logic [31:0]                     o_prdata,
  input wire logic                            o_pready,
  input wire logic                            o_pslverr,
  input wire logic [msq_pkg::NUM_OUT-1:0]     o_output_pins,
  input wire logic                            o_output_pins_oe,
  input wire logic [msq_pkg::NUM_SHARED-1:0]  o_shared_state_output_bits,
  input wire logic                            o_shared_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence setup_s;
    i_psel && !i_penable && i_clk_en;
  endsequence
  sequence preset_held_s;
    (PRESET_MODE && i_preset_or_enable_pin && i_clk_en)[*6];
  endsequence
  sequence quiet_s;
    (!i_seq_clk && !i_diag_select && !i_preset_or_enable_pin && !i_psel)[*8];
  endsequence
  pready_follow_a: assert property (o_pready == i_clk_en) else $error("pready differs from clock enable");
  reset_ones_a: assert property ($past(i_sys_rst) |-> o_output_pins == 4'hF && o_shared_state_output_bits == 2'h3)
    else $error("outputs not all ones after reset");
  unmapped_err_a: assert property (setup_s ##0 (i_paddr > msq_pkg::ADDR_INPUTS) |=> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup_s ##0 (i_paddr == msq_pkg::ADDR_STATUS) |=> !o_pslverr)
    else $error("mapped access refused");
  preset_ones_a: assert property (preset_held_s |-> o_output_pins == 4'hF && o_shared_state_output_bits == 2'h3)
    else $error("preset did not force ones");
  preset_oe_a: assert property (PRESET_MODE |-> o_output_pins_oe)
    else $error("outputs disabled in preset mode");
  oe_pair_a: assert property (o_shared_oe == o_output_pins_oe)
    else $error("output enables disagree");
  quiet_hold_a: assert property (quiet_s |-> $stable(o_output_pins) && $stable(o_shared_state_output_bits))
    else $error("outputs moved without a clock edge");
endmodule

// >>> msq_board.sv
`timescale 1ns/1ps
module msq_board (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_pins,
  input  wire logic       i_oe,
  output logic            o_seq_clk,
  output logic [3:0]      o_seen
);
  // Board pull-ups hold the pins high while the device floats them.
  assign o_seen = i_oe ? i_pins : 4'hF;
  initial o_seq_clk = 1'b0;
  // One clock pulse, slow enough for the synchroniser, then settle time.
  task automatic pulse();
    repeat (4) @(posedge i_clk);
    o_seq_clk <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_seq_clk <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// >>> programmable_mealy_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin miscompares++; $display("wrong value at %0t: %s", $time, msg); end end
module programmable_mealy_sequencer_bench;
  // Term 0 needs input 1 high and clears bit 0 of both registers; term 1 needs it low and sets them.
  localparam msq_pkg::msq_and_plane_type AT = msq_pkg::msq_and_plane_type'(1) << 1;
  localparam msq_pkg::msq_and_plane_type AC = msq_pkg::msq_and_plane_type'(1) << 24;
  localparam msq_pkg::msq_or_plane_type  SP = (msq_pkg::msq_or_plane_type'(1) << 385) | msq_pkg::msq_or_plane_type'(2);
  localparam msq_pkg::msq_or_plane_type  RP = (msq_pkg::msq_or_plane_type'(1) << 384) | msq_pkg::msq_or_plane_type'(1);
  logic        clk, rst, in0, diag, prst, psel, pen, pwr, pready, pslverr, oe, shoe, seqclk, e, ce;
  logic [13:1] ins;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pins, seen;
  logic [1:0]  sh;
  int          miscompares, num_checks, cyc;
  msq_sequencer #(.PRESET_MODE(1'b1), .AND_TRUE(AT), .AND_COMP(AC), .SET_PLANE(SP), .RST_PLANE(RP)) msq_sequencer_i (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(ce), .i_seq_clk(seqclk), .i_logic_or_diag_input(in0),
    .i_logic_inputs(ins), .i_diag_select(diag), .i_preset_or_enable_pin(prst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_output_pins(pins), .o_output_pins_oe(oe), .o_shared_state_output_bits(sh), .o_shared_oe(shoe));
  msq_board msq_board_i (.i_clk(clk), .i_pins(pins), .i_oe(oe), .o_seq_clk(seqclk), .o_seen(seen));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic look(input logic [3:0] p, input logic [1:0] s, input string m);
    repeat (5) @(posedge clk);
    `CHK(seen, p, m)
    `CHK(sh, s, m)
  endtask
  task automatic t_reset();
    look(4'hF, 2'h3, "power-on ones");
    `CHK({oe, shoe}, 2'b11, "outputs enabled")
    apb(msq_pkg::ADDR_STATUS, 1'b0, 32'h0);
    `CHK({e, rd}, 33'h0_0000_4FFF, "status after reset")
    apb(12'h00C, 1'b0, 32'h0);
    `CHK({e, rd}, 33'h1_0000_0000, "unmapped read")
  endtask
  task automatic t_step();
    ins[1] <= 1'b1;
    look(4'hF, 2'h3, "no edge no change");
    msq_board_i.pulse();
    look(4'hF, 2'h3, "first rise waits for fall");
    msq_board_i.pulse();
    look(4'hE, 2'h2, "reset command");
    ins[1] <= 1'b0;
    msq_board_i.pulse();
    look(4'hF, 2'h3, "set command");
    ins[1] <= 1'b1;
    msq_board_i.pulse();
    look(4'hE, 2'h2, "shared bit follows state");
  endtask
  task automatic t_diag();
    diag <= 1'b1;
    look(4'hF, 2'h3, "diag shows upper state");
    diag <= 1'b0;
    look(4'hE, 2'h2, "diag leaves contents");
    apb(msq_pkg::ADDR_CTRL, 1'b1, 32'h1);
    look(4'hF, 2'h3, "software diag");
    apb(msq_pkg::ADDR_CTRL, 1'b1, 32'h0);
    look(4'hE, 2'h2, "software diag off");
  endtask
  task automatic t_preset();
    prst <= 1'b1;
    look(4'hF, 2'h3, "preset forces ones");
    msq_board_i.pulse();
    look(4'hF, 2'h3, "preset inhibits clock");
    prst <= 1'b0;
    msq_board_i.pulse();
    look(4'hF, 2'h3, "rise before fall ignored");
    msq_board_i.pulse();
    look(4'hE, 2'h2, "clocking resumes");
  endtask
  // A set command is pending while the enable is low, so a leaking edge would show ones.
  task automatic t_freeze();
    ins[1] <= 1'b0;
    ce <= 1'b0;
    msq_board_i.pulse();
    look(4'hE, 2'h2, "clock enable freezes state");
    ce <= 1'b1;
    msq_board_i.pulse();
    look(4'hF, 2'h3, "clocking after enable returns");
    ins[1] <= 1'b1;
    msq_board_i.pulse();
    look(4'hE, 2'h2, "reset command again");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    look(4'hF, 2'h3, "reset in mid-run forces ones");
  endtask
  initial begin
    rst = 1'b1; in0 = 1'b0; ins = '0; diag = 1'b0; prst = 1'b0;
    psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = '0; pwdata = '0; ce = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_step();
    t_diag();
    t_preset();
    t_freeze();
    close_out();
  end
endmodule
bind msq_sequencer msq_monitor #(.PRESET_MODE(PRESET_MODE)) msq_monitor_i (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_seq_clk(i_seq_clk),
  .i_diag_select(i_diag_select), .i_preset_or_enable_pin(i_preset_or_enable_pin), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_output_pins(o_output_pins), .o_output_pins_oe(o_output_pins_oe),
  .o_shared_state_output_bits(o_shared_state_output_bits), .o_shared_oe(o_shared_oe));
